//--- pkg/gpio_port_consts.vh
// Constants for the general digital I/O port block.
// Assumes a 12-bit APB byte address with word-aligned registers.
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// Bus address layout
`define ADDR_W 12
`define PORT_REGION 4'h0
`define PORT_IDX_MSB 7
`define PORT_IDX_LSB 5
`define REG_SEL_MSB 4
`define REG_SEL_LSB 2

// Register selectors within one port window (byte offset = sel * 4)
`define REG_VALUE 3'h0
`define REG_DIR 3'h1
`define REG_SAMPLE 3'h2
`define REG_VALUE_SET 3'h3
`define REG_VALUE_CLR 3'h4
`define REG_DIR_SET 3'h5
`define REG_DIR_CLR 3'h6

// Global special function register
`define SPECIAL_ADDR 12'h100
`define PUD_BIT 0

// Reset values
`define VALUE_RESET_BIT 1'b0
`define DIR_RESET_BIT 1'b0
`define PUD_RESET 1'b0

`endif

//--- src/general_digital_io_port.v
// General digital I/O ports with an APB register slave.
// Assumes pin_i comes straight from the pads; pads resolve pin_o, pin_oe
// and pullup_en into the wire level.
// Function
// [RULE1] Each port has value and direction registers read/write, plus read-only input sample.
// [RULE2] Global pull-up disable set turns off every pull-up in every port.
// [RULE3] Direction one makes the pin an output, zero an input.
// [RULE4] Pull-up on only for input, value one and global disable zero.
// [RULE5] Reset asserted tri-states every pin at once, without any clock.
// [RULE6] Output pin drives high for value one, low for value zero.
// [RULE7] Software goes from hi-Z to output high via pull-up or output low.
// [RULE8] Software goes between pull-up input and output low via hi-Z or high.
// [RULE9] Input sample shows the pin level whatever the direction.
// [RULE10] Pin passes a clock-high transparent stage, then a rising-edge sample; the code uses a falling-edge register, not a latch.
// [RULE11] Pin change reaches the sample bit after half to one and a half periods.
// [RULE12] A written value reaches the sample one period after the write edge.
// [RULE13] Bit set and clear change only addressed bits of value or direction.
// [RULE14] Pins of a port behave independently of the other pins.
// [RULE15] Strobes are shared per port; clock, sleep and pull-up disable by all.
// [RULE16] In deep sleep each digital input is clamped low unless overridden.
// [RULE17] Direction and value reset to zero: hi-Z inputs without pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.vh"

module general_digital_io_port #(
   parameter NUM_PORTS = 2,
   parameter PORT_WIDTH = 8
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire [`ADDR_W-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Pads
   input wire [NUM_PORTS*PORT_WIDTH-1:0] pin_i,
   output wire [NUM_PORTS*PORT_WIDTH-1:0] pin_o,
   output wire [NUM_PORTS*PORT_WIDTH-1:0] pin_oe,
   output wire [NUM_PORTS*PORT_WIDTH-1:0] pullup_en,
   // Sleep controller
   input wire sleep_clamp,
   input wire [NUM_PORTS*PORT_WIDTH-1:0] input_enable_override
);

   localparam NPINS = NUM_PORTS * PORT_WIDTH;
   localparam [3:0] NUM_PORTS_W = NUM_PORTS;

   // Bus phase decode
   wire setup_phase = psel & ~penable;
   wire write_access = psel & penable & pwrite;
   wire read_setup = setup_phase & ~pwrite;
   wire [2:0] port_idx = paddr[`PORT_IDX_MSB:`PORT_IDX_LSB];
   wire [2:0] reg_sel = paddr[`REG_SEL_MSB:`REG_SEL_LSB];
   wire in_port_region = (paddr[`ADDR_W-1:8] == `PORT_REGION);
   wire port_hit = in_port_region && ({1'b0, port_idx} < NUM_PORTS_W) &&
      (reg_sel <= `REG_DIR_CLR) && (paddr[1:0] == 2'h0);
   wire special_hit = (paddr == `SPECIAL_ADDR);

   // Per-port strobes, common to all pins of a port
   wire [NUM_PORTS-1:0] value_reg_write_strobe;
   wire [NUM_PORTS-1:0] value_set_strobe;
   wire [NUM_PORTS-1:0] value_clear_strobe;
   wire [NUM_PORTS-1:0] direction_reg_write_strobe;
   wire [NUM_PORTS-1:0] direction_set_strobe;
   wire [NUM_PORTS-1:0] direction_clear_strobe;
   wire [NUM_PORTS-1:0] value_reg_read_strobe;
   wire [NUM_PORTS-1:0] direction_reg_read_strobe;
   wire [NUM_PORTS-1:0] pin_sample_read_strobe;

   // Flat per-pin state
   wire [NPINS-1:0] pin_output_value_bit;
   wire [NPINS-1:0] pin_direction_bit;
   wire [NPINS-1:0] port_read_words;
   reg [NPINS-1:0] sync_stage_q;
   reg [NPINS-1:0] pin_input_sample_bit;
   reg global_pullup_disable;

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
         reg [PORT_WIDTH-1:0] value_q;
         reg [PORT_WIDTH-1:0] dir_q;
         wire [PORT_WIDTH-1:0] wbits = pwdata[PORT_WIDTH-1:0];
         wire sel_w = write_access & port_hit & (port_idx == p);
         wire sel_r = read_setup & port_hit & (port_idx == p);

         assign value_reg_write_strobe[p] = sel_w & (reg_sel == `REG_VALUE); // RULE15
         assign value_set_strobe[p] = sel_w & (reg_sel == `REG_VALUE_SET);
         assign value_clear_strobe[p] = sel_w & (reg_sel == `REG_VALUE_CLR);
         assign direction_reg_write_strobe[p] = sel_w & (reg_sel == `REG_DIR); // RULE15
         assign direction_set_strobe[p] = sel_w & (reg_sel == `REG_DIR_SET);
         assign direction_clear_strobe[p] = sel_w & (reg_sel == `REG_DIR_CLR);
         assign value_reg_read_strobe[p] = sel_r & (reg_sel == `REG_VALUE);
         assign direction_reg_read_strobe[p] = sel_r & (reg_sel == `REG_DIR);
         assign pin_sample_read_strobe[p] = sel_r & (reg_sel == `REG_SAMPLE);

         // Value register: whole write, or per-bit set/clear
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               value_q <= {PORT_WIDTH{`VALUE_RESET_BIT}}; // RULE17
            end else if (value_reg_write_strobe[p]) begin
               value_q <= wbits; // RULE1
            end else if (value_set_strobe[p]) begin
               value_q <= value_q | wbits; // RULE13
            end else if (value_clear_strobe[p]) begin
               value_q <= value_q & ~wbits; // RULE13
            end
         end

         // Direction register: whole write, or per-bit set/clear
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dir_q <= {PORT_WIDTH{`DIR_RESET_BIT}}; // RULE17
            end else if (direction_reg_write_strobe[p]) begin
               dir_q <= wbits; // RULE1
            end else if (direction_set_strobe[p]) begin
               dir_q <= dir_q | wbits; // RULE13
            end else if (direction_clear_strobe[p]) begin
               dir_q <= dir_q & ~wbits; // RULE13
            end
         end

         // Bitwise per-pin state, no cross-pin coupling
         assign pin_output_value_bit[p*PORT_WIDTH +: PORT_WIDTH] = value_q; // RULE14
         assign pin_direction_bit[p*PORT_WIDTH +: PORT_WIDTH] = dir_q; // RULE14

         // Read word of this port, gated by its shared read strobes
         assign port_read_words[p*PORT_WIDTH +: PORT_WIDTH] =
            ({PORT_WIDTH{value_reg_read_strobe[p]}} & value_q) |
            ({PORT_WIDTH{direction_reg_read_strobe[p]}} & dir_q) |
            ({PORT_WIDTH{pin_sample_read_strobe[p]}} &
             pin_input_sample_bit[p*PORT_WIDTH +: PORT_WIDTH]); // RULE1
      end
   endgenerate

   // Global pull-up disable register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_pullup_disable <= `PUD_RESET;
      end else if (write_access && special_hit) begin
         global_pullup_disable <= pwdata[`PUD_BIT]; // RULE15
      end
   end

   // Pad drive; reset gates enables without a clock
   assign pin_oe = presetn ? pin_direction_bit : {NPINS{1'b0}}; // RULE3 RULE5
   assign pin_o = pin_output_value_bit; // RULE6
   assign pullup_en = (presetn && !global_pullup_disable) ?
      (~pin_direction_bit & pin_output_value_bit) : {NPINS{1'b0}}; // RULE2 RULE4

   // Sleep clamp ahead of the synchroniser
   wire [NPINS-1:0] clamp_vec = {NPINS{sleep_clamp}} & ~input_enable_override;
   wire [NPINS-1:0] pin_gated = pin_i & ~clamp_vec; // RULE16

   // Stage holding the pin while the clock is low, as a high-phase latch would
   always @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_stage_q <= {NPINS{1'b0}};
      end else begin
         sync_stage_q <= pin_gated; // RULE10
      end
   end

   // Rising-edge sample; pad level read whatever the direction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_input_sample_bit <= {NPINS{1'b0}};
      end else begin
         pin_input_sample_bit <= sync_stage_q; // RULE9 RULE10 RULE11 RULE12
      end
   end

   // Read data and error captured in the setup cycle
   reg [PORT_WIDTH-1:0] read_mux;
   reg [31:0] prdata_q;
   reg [31:0] prdata_d;
   reg pslverr_q;
   integer k;

   always @* begin
      read_mux = {PORT_WIDTH{1'b0}};
      for (k = 0; k < NUM_PORTS; k = k + 1) begin
         read_mux = read_mux | port_read_words[k*PORT_WIDTH +: PORT_WIDTH];
      end
      prdata_d = 32'h00000000;
      if (special_hit) begin
         prdata_d[`PUD_BIT] = global_pullup_disable;
      end else if (port_hit) begin
         prdata_d[PORT_WIDTH-1:0] = read_mux;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup_phase) begin
         prdata_q <= pwrite ? 32'h00000000 : prdata_d;
         pslverr_q <= ~(port_hit | special_hit);
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = 1'b1;

endmodule // general_digital_io_port

`default_nettype wire

//--- bench/gpio_pads_model.sv
// Board model: a pad follows the port drive, an outside source or the pull-up.
// A pad that nobody drives toggles each cycle, so it never reads as settled.
`timescale 1ns/100ps
`default_nettype none
module gpio_pads_model #(parameter W = 16) (
   input wire logic pclk,
   // Port and board drive
   input wire logic [W-1:0] pin_o, input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] pullup_en, input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val, output logic [W-1:0] pin_i
);
   logic [W-1:0] float_q = '0;
   always @(posedge pclk) float_q <= ~float_q;
   assign pin_i = pin_oe & pin_o | ~pin_oe & (ext_en & ext_val | ~ext_en & (pullup_en | float_q));
endmodule // gpio_pads_model
`default_nettype wire

//--- bench/gpio_port_properties.sv
// Checker for the I/O port: pin controls against register writes.
// Bound into the port top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.vh"
module gpio_port_properties #(parameter NUM_PORTS = 2, parameter PORT_WIDTH = 8,
   localparam W = NUM_PORTS * PORT_WIDTH) (
   // Clock, reset and bus
   input wire pclk, input wire presetn, input wire [`ADDR_W-1:0] paddr, input wire psel,
   input wire penable, input wire pwrite, input wire [31:0] pwdata, input wire [31:0] prdata,
   input wire pready, input wire pslverr,
   // Pads and sleep
   input wire [W-1:0] pin_i, input wire [W-1:0] pin_o, input wire [W-1:0] pin_oe,
   input wire [W-1:0] pullup_en, input wire sleep_clamp, input wire [W-1:0] input_enable_override
);
   reg pud_q;
   wire acc = psel & penable & pwrite;
   // Shadow of the global pull-up disable
   always @(posedge pclk or negedge presetn)
      if (!presetn) pud_q <= 1'b0;
      else if (acc && paddr == `SPECIAL_ADDR) pud_q <= pwdata[`PUD_BIT];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RST_IDLE: assert property ($rose(presetn) |-> pin_oe == 0 && pin_o == 0)
      else $error("pins busy after reset");
   AST_PULL_OFF: assert property ((pullup_en & (pin_oe | ~pin_o)) == 0)
      else $error("stray pull-up");
   AST_PULL_ON: assert property (!pud_q |-> pullup_en == (~pin_oe & pin_o))
      else $error("pull-up missing");
   AST_PUD: assert property (pud_q |-> pullup_en == 0) else $error("pull-up not disabled");
   AST_VAL_WR: assert property (acc && paddr == 12'h000 |=> pin_o[7:0] == $past(pwdata[7:0]))
      else $error("drive value lost");
   AST_DIR_WR: assert property (acc && paddr == 12'h024 |=> pin_oe[15:8] == $past(pwdata[7:0]))
      else $error("direction lost");
   AST_SET: assert property (acc && paddr == 12'h00C |=> $stable(pin_oe) &&
      pin_o[7:0] == ($past(pin_o[7:0]) | $past(pwdata[7:0]))) else $error("bit set spilled");
   AST_SAMPLE: assert property (psel && !penable && paddr == 12'h008 && !sleep_clamp &&
      !$past(sleep_clamp) && $stable(pin_i) && $past(presetn, 3)
      |=> prdata[7:0] == $past(pin_i[7:0])) else $error("sample differs from pin");
   COV_PUD: cover property (acc && paddr == `SPECIAL_ADDR && pwdata[0]);
   COV_SAMPLE: cover property (psel && penable && !pwrite && paddr == 12'h008);
   COV_ERR: cover property (psel && penable && pslverr);
endmodule // gpio_port_properties
bind general_digital_io_port gpio_port_properties #(.NUM_PORTS(NUM_PORTS),
   .PORT_WIDTH(PORT_WIDTH)) i_props (.*);
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: APB traffic and board drive, with pin and register checks.
// Assumes the bound checker and the board model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_consts.vh"
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic sleep_clamp = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic [15:0] input_enable_override = 16'h0, ext_en = 16'hC300, ext_val = 16'h4200;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [15:0] pin_i, pin_o, pin_oe, pullup_en;
   int err_count = 0, num_checks = 0;
   always #5 pclk = ~pclk;
   general_digital_io_port i_dut (.*);
   gpio_pads_model i_pads (.*);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic close_out;
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic t_reset;
      chk("oe_rst", pin_oe, 16'h0);
      chk("pu_rst", pullup_en, 16'h0);
      apb(1'b1, 12'h004, 32'hFF);
      chk("oe_on", pin_oe, 16'h00FF);
      @(posedge pclk);
      presetn <= 1'b0;
      #1 chk("oe_async", pin_oe, 16'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("dir_rst", rd, 32'h0);
   endtask
   task automatic t_regs;
      apb(1'b1, 12'h020, 32'hA5);
      apb(1'b1, 12'h024, 32'h3C);
      apb(1'b1, 12'h028, 32'hFF);
      apb(1'b0, 12'h024, 32'h0);
      chk("dir1", rd, 32'h3C);
      apb(1'b0, 12'h028, 32'h0);
      chk("pins1", rd, 32'h3C & 32'hA5 | 32'hC3 & 32'h42);
      apb(1'b0, 12'h0FC, 32'h0);
      chk("unmapped", e, 1'b1);
   endtask
   task automatic t_pull;
      apb(1'b1, 12'h000, 32'hFF);
      apb(1'b1, 12'h004, 32'h0F);
      chk("pu", pullup_en, 16'h81F0);
      chk("drive", pin_o & pin_oe, 16'h240F);
      apb(1'b1, `SPECIAL_ADDR, 32'h1);
      chk("pud", pullup_en, 16'h0);
      apb(1'b0, `SPECIAL_ADDR, 32'h0);
      chk("pud_rd", rd, 32'h1);
      apb(1'b1, `SPECIAL_ADDR, 32'h0);
   endtask
   task automatic t_setclr;
      apb(1'b1, 12'h010, 32'h81);
      apb(1'b1, 12'h018, 32'h01);
      apb(1'b1, 12'h014, 32'h80);
      apb(1'b1, 12'h00C, 32'h01);
      chk("set_v", pin_o, 16'hA57F);
      chk("set_d", pin_oe, 16'h3C8E);
      chk("set_p", pullup_en, 16'h8171);
   endtask
   task automatic t_sample;
      apb(1'b1, 12'h000, 32'h7D);
      apb(1'b0, 12'h008, 32'h0);
      chk("wr_back", rd, 32'h7D);
      @(posedge pclk);
      ext_val <= 16'h4300;
      apb(1'b0, 12'h028, 32'h0);
      chk("edge", rd, 32'h67);
      @(posedge pclk);
      sleep_clamp <= 1'b1;
      input_enable_override <= 16'h0100;
      apb(1'b0, 12'h028, 32'h0);
      chk("clamp", rd, 32'h01);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_regs;
      t_pull;
      t_setclr;
      t_sample;
      close_out;
   end
   initial begin
      #20000;
      err_count++;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
